// ===== rtl/atae_engine.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module atae_engine (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [atae_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [atae_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import atae_pkg::*;

  // ---------------------------------------------------------------------
  // state, helpers
  // ---------------------------------------------------------------------
  atae_state_s s_r;
  atae_state_s s_nxt;
  atae_entry_s rd_e;
  atae_entry_s ctl_e;
  logic [69:0] mem_rdata;
  logic mem_we;
  logic do_wr;
  logic wr_go;
  logic legal_go;
  logic srch_hit_c;
  logic set_match;
  logic [2:0] go_cmd;
  logic [3:0] go_acc;
  logic [2:0] cur_cmd;
  logic [3:0] cur_acc;
  logic [8:0] widx;
  logic [8:0] ridx;
  logic [2:0] cidx;
  logic [15:0] rword;
  logic [1:0] tgt_way;
  logic tgt_ok;

  // ---------------------------------------------------------------------
  // table memory
  // ---------------------------------------------------------------------
  assign mem_we = (s_r.fsm == FSM_CLEAR) || (s_r.fsm == FSM_WRITE);

  atae_table_mem #(
    .DEPTH(TBL_DEPTH),
    .AW(TBL_AW),
    .W(70)
  ) u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .addr(s_r.addr),
    .wdata(s_r.wentry),
    .rdata(mem_rdata)
  );

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    rd_e = atae_entry_s'(mem_rdata);
    ctl_e = '0;
    ctl_e.mac = {s_r.ctrl[2], s_r.ctrl[1], s_r.ctrl[0]};
    ctl_e.group = s_r.ctrl[3][F_GRP_LSB+:4];
    ctl_e.ports = s_r.ctrl[3][F_PORTS_LSB+:6];
    ctl_e.info = s_r.ctrl[4][F_INFO_LSB+:9];
    ctl_e.static_f = s_r.ctrl[4][F_STATIC_BIT];
    ctl_e.occupy = 1'b1;
    cur_cmd = s_r.ctrl[5][F_CMD_LSB+:3];
    cur_acc = s_r.ctrl[5][F_ACC_LSB+:4];
    widx = s_r.awaddr[ADDR_W-1:2];
    ridx = s_axi_araddr[ADDR_W-1:2];
    cidx = 3'(widx - IDX_CTRL0);
    rword = 16'h0000;
    srch_hit_c = srch_match(rd_e, ctl_e, cur_acc);
    set_match = rd_e.occupy && rd_e.mac == ctl_e.mac &&
                rd_e.group == ctl_e.group;
    tgt_ok = 1'b0;
    tgt_way = 2'h0;

    // write channels; address and data may arrive in either order
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata[15:0];
      s_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    do_wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    if (do_wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      // control words are frozen while a command runs
      if (widx >= IDX_CTRL0 && widx <= IDX_CTRL5 &&
          s_r.fsm == FSM_IDLE) begin
        s_nxt.ctrl[cidx] = merge16(s_r.ctrl[cidx], s_r.wdata, s_r.wstrb);
      end
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

    // read channel
    if (ridx >= IDX_CTRL0 && ridx <= IDX_CTRL5) begin
      rword = s_r.ctrl[3'(ridx - IDX_CTRL0)];
    end else begin
      case (ridx)
        IDX_STAT0: rword = s_r.st.mac[15:0];
        IDX_STAT1: rword = s_r.st.mac[31:16];
        IDX_STAT2: rword = s_r.st.mac[47:32];
        IDX_STAT3: rword = {6'h00, s_r.st.ports, s_r.st.group};
        IDX_STAT4: rword = {7'h00, s_r.st.info};
        IDX_STAT5: rword = {s_r.fsm != FSM_IDLE, s_r.res, 9'h000,
                            s_r.st.bad, s_r.st.occupy, s_r.st.static_f};
        default: rword = 16'h0000;
      endcase
    end
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = {16'h0000, rword};
      s_nxt.rresp = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // command launch
    wr_go = do_wr && widx == IDX_CTRL5 && s_r.fsm == FSM_IDLE;
    go_cmd = s_nxt.ctrl[5][F_CMD_LSB+:3];
    go_acc = s_nxt.ctrl[5][F_ACC_LSB+:4];
    legal_go = cmd_legal(go_cmd, go_acc);

    // engine
    case (s_r.fsm)
      FSM_CLEAR: begin
        s_nxt.wentry = '0;
        if (s_r.cur == CUR_LAST) begin
          s_nxt.fsm = FSM_IDLE;
          s_nxt.cur = PTR_RST;
        end else begin
          s_nxt.cur = s_r.cur + 12'h001;
          s_nxt.addr = TBL_AW'(s_r.cur + 12'h001);
        end
      end
      FSM_IDLE: begin
        if (wr_go) begin
          if (!legal_go) begin
            s_nxt.res = RES_ERR;
            s_nxt.fsm = FSM_FIN;
          end else if (go_cmd == CMD_INIT) begin
            s_nxt.ptr = (go_acc == ACC_LOC) ?
              {1'b0, atae_hash(ctl_e.mac, ctl_e.group), 2'h0} : PTR_RST;
            s_nxt.res = RES_OK;
            s_nxt.fsm = FSM_FIN;
          end else if (go_cmd == CMD_SEARCH) begin
            if (s_r.ptr[11]) begin
              s_nxt.res = RES_NOT_FOUND;
              s_nxt.fsm = FSM_FIN;
            end else begin
              s_nxt.cur = s_r.ptr;
              s_nxt.addr = s_r.ptr[TBL_AW-1:0];
              s_nxt.fsm = FSM_READ;
            end
          end else begin
            s_nxt.addr = {atae_hash(ctl_e.mac, ctl_e.group), 2'h0};
            s_nxt.hit = 1'b0;
            s_nxt.slot = 1'b0;
            s_nxt.slot_empty = 1'b0;
            s_nxt.fsm = FSM_READ;
          end
        end
      end
      FSM_READ: begin
        s_nxt.fsm = FSM_CHECK;
      end
      FSM_CHECK: begin
        if (cur_cmd == CMD_SEARCH) begin
          if (srch_hit_c) begin
            s_nxt.st = rd_e;
            s_nxt.res = RES_OK;
            s_nxt.ptr = s_r.cur + 12'h001;
            s_nxt.fsm = FSM_FIN;
          end else if (s_r.cur == CUR_LAST) begin
            s_nxt.res = RES_NOT_FOUND;
            s_nxt.ptr = PTR_END;
            s_nxt.fsm = FSM_FIN;
          end else begin
            s_nxt.cur = s_r.cur + 12'h001;
            s_nxt.addr = TBL_AW'(s_r.cur + 12'h001);
            s_nxt.fsm = FSM_READ;
          end
        end else begin
          // one way per visit: remember a match and a usable slot
          if (set_match && !s_r.hit) begin
            s_nxt.hit = 1'b1;
            s_nxt.hit_way = s_r.addr[1:0];
          end
          if (!rd_e.occupy && !s_r.slot_empty) begin
            s_nxt.slot = 1'b1;
            s_nxt.slot_empty = 1'b1;
            s_nxt.slot_way = s_r.addr[1:0];
          end else if (rd_e.occupy && !rd_e.static_f && !s_r.slot) begin
            s_nxt.slot = 1'b1;
            s_nxt.slot_way = s_r.addr[1:0];
          end
          if (s_r.addr[1:0] != 2'h3) begin
            s_nxt.addr = s_r.addr + TBL_AW'(1);
            s_nxt.fsm = FSM_READ;
          end else begin
            if (s_nxt.hit) begin
              tgt_ok = 1'b1;
              tgt_way = s_nxt.hit_way;
            end else if (cur_acc == ACC_CREATE && s_nxt.slot) begin
              tgt_ok = 1'b1;
              tgt_way = s_nxt.slot_way;
            end
            if (tgt_ok) begin
              s_nxt.addr = {s_r.addr[TBL_AW-1:2], tgt_way};
              s_nxt.wentry = (cur_cmd == CMD_ERASE) ? '0 : ctl_e;
              s_nxt.res = RES_OK;
              s_nxt.fsm = FSM_WRITE;
            end else begin
              // a set of four static ways refuses a create
              s_nxt.res = (cur_acc == ACC_CREATE) ? RES_FULL
                                                  : RES_NOT_FOUND;
              s_nxt.fsm = FSM_FIN;
            end
          end
        end
      end
      FSM_WRITE: begin
        s_nxt.fsm = FSM_IDLE;
      end
      FSM_FIN: begin
        s_nxt.fsm = FSM_IDLE;
      end
      default: begin
        s_nxt.fsm = FSM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_launch;
    wr_go;
  endsequence

  sequence s_err_done;
    (s_r.res == RES_ERR && s_r.fsm == FSM_FIN) ##1 (s_r.fsm == FSM_IDLE);
  endsequence

  property p_busy_set;
    s_launch |=> (s_r.fsm != FSM_IDLE);
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy did not rise after command launch");

  property p_busy_read;
    (s_r.arready && s_axi_arvalid && ridx == IDX_STAT5) |=>
      (s_r.rdata[F_BUSY_BIT] == ($past(s_r.fsm) != FSM_IDLE));
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("busy bit read back differs from engine state");

  property p_err;
    (wr_go && !legal_go) |=> s_err_done;
  endproperty
  a_err: assert property (p_err)
    else $error("undefined command did not end in command error");

  property p_full_only_create;
    (s_r.res == RES_FULL && $changed(s_r.res)) |->
      (cur_cmd == CMD_WRITE && cur_acc == ACC_CREATE);
  endproperty
  a_full_only_create: assert property (p_full_only_create)
    else $error("all-used result for a command other than create");

  property p_ptr_first;
    (wr_go && legal_go && go_cmd == CMD_INIT && go_acc == ACC_FIRST) |=>
      (s_r.ptr == PTR_RST) ##1 (s_r.fsm == FSM_IDLE);
  endproperty
  a_ptr_first: assert property (p_ptr_first)
    else $error("search pointer not reset to first location");

  property p_ptr_loc;
    (wr_go && go_cmd == CMD_INIT && go_acc == ACC_LOC) |=>
      (s_r.ptr == {1'b0, atae_hash(ctl_e.mac, ctl_e.group), 2'h0});
  endproperty
  a_ptr_loc: assert property (p_ptr_loc)
    else $error("search pointer not set to address location");

  property p_create_wr;
    (s_r.fsm == FSM_WRITE && cur_cmd == CMD_WRITE) |->
      (s_r.wentry.occupy && s_r.wentry.mac == ctl_e.mac &&
       s_r.wentry.group == ctl_e.group && s_r.res == RES_OK);
  endproperty
  a_create_wr: assert property (p_create_wr)
    else $error("created entry differs from control words");

  property p_erase;
    (s_r.fsm == FSM_WRITE && cur_cmd == CMD_ERASE) |-> !s_r.wentry.occupy;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase left the entry occupied");

  property p_search_load;
    (s_r.fsm == FSM_CHECK && cur_cmd == CMD_SEARCH && srch_hit_c) |=>
      (s_r.st.mac == $past(rd_e.mac) && s_r.res == RES_OK) ##1
      (s_r.fsm == FSM_IDLE);
  endproperty
  a_search_load: assert property (p_search_load)
    else $error("search hit not loaded into status");

endmodule

// ===== rtl/atae_pkg.sv
package atae_pkg;

  // ---------------------------------------------------------------------
  // sizes and register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int TBL_DEPTH = 2048;
  localparam int TBL_AW = 11;
  localparam int SET_W = 9;
  localparam logic [8:0] IDX_CTRL0 = 9'h11A;
  localparam logic [8:0] IDX_CTRL5 = 9'h11F;
  localparam logic [8:0] IDX_STAT0 = 9'h120;
  localparam logic [8:0] IDX_STAT1 = 9'h121;
  localparam logic [8:0] IDX_STAT2 = 9'h122;
  localparam logic [8:0] IDX_STAT3 = 9'h123;
  localparam logic [8:0] IDX_STAT4 = 9'h124;
  localparam logic [8:0] IDX_STAT5 = 9'h125;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int F_ACC_LSB = 0;
  localparam int F_CMD_LSB = 4;
  localparam int F_GRP_LSB = 0;
  localparam int F_PORTS_LSB = 4;
  localparam int F_INFO_LSB = 0;
  localparam int F_STATIC_BIT = 12;
  localparam int F_BUSY_BIT = 15;
  localparam int F_RES_LSB = 12;

  // ---------------------------------------------------------------------
  // commands, access codes, results, bus answers
  // ---------------------------------------------------------------------
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_ERASE = 3'h1;
  localparam logic [2:0] CMD_SEARCH = 3'h2;
  localparam logic [2:0] CMD_INIT = 3'h3;
  localparam logic [3:0] ACC_CREATE = 4'h7;
  localparam logic [3:0] ACC_ALL = 4'hF;
  localparam logic [3:0] ACC_EMPTY = 4'h0;
  localparam logic [3:0] ACC_LOC = 4'h4;
  localparam logic [3:0] ACC_FIRST = 4'h0;
  localparam logic [3:0] ACC_NONE = 4'h8;
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_FULL = 3'h1;
  localparam logic [2:0] RES_NOT_FOUND = 3'h2;
  localparam logic [2:0] RES_ERR = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [11:0] PTR_END = 12'h800;
  localparam logic [11:0] CUR_LAST = 12'h7FF;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [5:0] {
    FSM_IDLE = 6'h01,
    FSM_CLEAR = 6'h02,
    FSM_READ = 6'h04,
    FSM_CHECK = 6'h08,
    FSM_WRITE = 6'h10,
    FSM_FIN = 6'h20
  } atae_fsm_e;

  typedef struct packed {
    logic bad;
    logic static_f;
    logic occupy;
    logic [8:0] info;
    logic [5:0] ports;
    logic [3:0] group;
    logic [47:0] mac;
  } atae_entry_s;

  typedef struct packed {
    atae_fsm_e fsm;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0][15:0] ctrl;
    atae_entry_s st;
    logic [2:0] res;
    logic [11:0] ptr;
    logic [11:0] cur;
    logic hit;
    logic [1:0] hit_way;
    logic slot;
    logic slot_empty;
    logic [1:0] slot_way;
    logic [TBL_AW-1:0] addr;
    atae_entry_s wentry;
  } atae_state_s;

  localparam atae_state_s ST_RST = '{fsm: FSM_CLEAR, default: '0};

  // set index from the learning key, address plus forwarding group
  function automatic logic [SET_W-1:0] atae_hash(input logic [47:0] mac,
                                                 input logic [3:0] grp);
    atae_hash = mac[8:0] ^ mac[17:9] ^ mac[26:18] ^ mac[35:27] ^
                mac[44:36] ^ {2'h0, grp, mac[47:45]};
  endfunction

  function automatic logic cmd_legal(input logic [2:0] c,
                                     input logic [3:0] a);
    case (c)
      CMD_WRITE: cmd_legal = (a == ACC_CREATE) || (a == ACC_ALL);
      CMD_ERASE: cmd_legal = (a == ACC_ALL);
      CMD_SEARCH: cmd_legal = (a == ACC_EMPTY) || (a[3] && a != ACC_NONE);
      CMD_INIT: cmd_legal = (a == ACC_LOC) || (a == ACC_FIRST);
      default: cmd_legal = 1'b0;
    endcase
  endfunction

  // bit 2 selects address, bit 1 group, bit 0 ports
  function automatic logic srch_match(input atae_entry_s e,
                                      input atae_entry_s k,
                                      input logic [3:0] a);
    if (a == ACC_EMPTY) begin
      srch_match = !e.occupy;
    end else begin
      srch_match = e.occupy &&
                   (!a[2] || e.mac == k.mac) &&
                   (!a[1] || e.group == k.group) &&
                   (!a[0] || (e.ports & k.ports) != 6'h00);
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic is_mapped(input logic [8:0] idx);
    is_mapped = (idx >= IDX_CTRL0) && (idx <= IDX_STAT5);
  endfunction

endpackage

// ===== rtl/atae_table_mem.sv
`timescale 1ns/1ps
module atae_table_mem #(
  parameter int DEPTH = atae_pkg::TBL_DEPTH,
  parameter int AW = atae_pkg::TBL_AW,
  parameter int W = 70
) (
  // clock
  input wire logic core_clk,
  // access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);
  import atae_pkg::*;

  // no reset on the array; the engine sweeps it clear after reset
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import atae_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk, resetn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  int err_count, num_checks;
  logic [3:0] codes [7] = '{4'h9, 4'hA, 4'hC, 4'hE, 4'hD, 4'hB, 4'hF};
  logic [47:0] mac_e;

  atae_engine dut (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo(input bit bad);
    if (bad) begin
      err_count++;
      $display("MISMATCH t=%0t wait timed out", $time);
      end_sim();
    end
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // master holds each channel until its own handshake edge
  task automatic wr(input logic [8:0] idx, input logic [15:0] d);
    int n;
    bit a, w;
    n = 0;
    a = 0;
    w = 0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(a && w) && n < 200);
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_bvalid && n < 200);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n >= 200);
  endtask

  task automatic rdr(input logic [8:0] idx);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_arready && n < 200);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_rvalid && n < 200);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n >= 200);
  endtask

  // the table clear after reset takes 2048 cycles, hence the bound
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      rdr(IDX_STAT5);
      k++;
    end while (rd[15] !== 1'b0 && k < 3000);
    tmo(k >= 3000);
  endtask

  task automatic load(input logic [47:0] m, input logic [5:0] p,
                      input logic [3:0] g, input logic [8:0] inf,
                      input logic st);
    wr(IDX_CTRL0, m[15:0]);
    wr(IDX_CTRL0 + 9'h1, m[31:16]);
    wr(IDX_CTRL0 + 9'h2, m[47:32]);
    wr(IDX_CTRL0 + 9'h3, {6'h00, p, g});
    wr(IDX_CTRL0 + 9'h4, {3'h0, st, 3'h0, inf});
  endtask

  task automatic cmd(input logic [2:0] c, input logic [3:0] a,
                     input logic [2:0] er);
    wr(IDX_CTRL5, {9'h000, c, a});
    wait_idle();
    check(rd[14:12], er);
  endtask

  task automatic chkent(input logic [47:0] m, input logic [5:0] p,
                        input logic [3:0] g, input logic [8:0] inf,
                        input logic st);
    logic [5:0][15:0] e;
    e = {{15'h0001, st}, {7'h00, inf}, {6'h00, p, g}, m};
    for (int i = 0; i < 6; i++) begin
      rdr(IDX_STAT0 + 9'(i));
      check(rd, {16'h0000, e[i]});
    end
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    err_count = 0;
    num_checks = 0;
    mac_e = 48'h0012_3456_789A;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    wait_idle();
    rdr(IDX_STAT0);
    check(rd, 48'h0);
    rdr(9'h119);
    check({rsp, rd}, {RESP_SLVERR, 32'h0});
    rdr(9'h126);
    check({rsp, rd}, {RESP_SLVERR, 32'h0});
    wr(IDX_STAT3, 16'hFFFF);
    check(rsp, RESP_OKAY);
    wr(9'h126, 16'h1234);
    check(rsp, RESP_SLVERR);
    rdr(IDX_STAT3);
    check(rd, 48'h0);
    s_axi_wstrb <= 4'h1;
    wr(IDX_CTRL0, 16'hABCD);
    s_axi_wstrb <= 4'hF;
    rdr(IDX_CTRL0);
    check(rd, 48'h00CD);
    load(mac_e, 6'h08, 4'h2, 9'h1A5, 1'b1);
    rdr(IDX_CTRL0 + 9'h4);
    check(rd, 48'h11A5);
    wr(IDX_CTRL5, {9'h000, CMD_WRITE, ACC_CREATE});
    rdr(IDX_STAT5);
    check(rd[15], 1'b1);
    wr(IDX_CTRL0, 16'h5555);
    wait_idle();
    check(rd[14:12], RES_OK);
    rdr(IDX_CTRL0);
    check(rd, 48'h789A);
    foreach (codes[i]) begin
      cmd(CMD_INIT, ACC_FIRST, RES_OK);
      cmd(CMD_SEARCH, codes[i], RES_OK);
      chkent(mac_e, 6'h08, 4'h2, 9'h1A5, 1'b1);
    end
    cmd(CMD_SEARCH, 4'hC, RES_NOT_FOUND);
    cmd(CMD_INIT, ACC_FIRST, RES_OK);
    cmd(CMD_SEARCH, ACC_EMPTY, RES_OK);
    check(rd[1], 1'b0);
    cmd(CMD_INIT, ACC_LOC, RES_OK);
    cmd(CMD_SEARCH, 4'hC, RES_OK);
    cmd(3'h7, 4'h5, RES_ERR);
    cmd(CMD_WRITE, 4'h3, RES_ERR);
    cmd(CMD_INIT, ACC_FIRST, RES_OK);
    cmd(CMD_SEARCH, 4'hF, RES_OK);
    cmd(CMD_ERASE, ACC_ALL, RES_OK);
    cmd(CMD_INIT, ACC_FIRST, RES_OK);
    cmd(CMD_SEARCH, 4'hC, RES_NOT_FOUND);
    // keys below share one set: the two low 9-bit slices cancel
    for (int x = 1; x < 6; x++) begin
      load({30'h0, x[8:0], x[8:0]}, 6'h01, 4'h1, 9'h000, 1'b1);
      cmd(CMD_WRITE, ACC_CREATE, (x == 5) ? RES_FULL : RES_OK);
    end
    load({30'h0, 9'h001, 9'h001}, 6'h3C, 4'h1, 9'h000, 1'b1);
    cmd(CMD_WRITE, ACC_ALL, RES_OK);
    cmd(CMD_INIT, ACC_FIRST, RES_OK);
    cmd(CMD_SEARCH, 4'hE, RES_OK);
    chkent({30'h0, 9'h001, 9'h001}, 6'h3C, 4'h1, 9'h000, 1'b1);
    load({30'h0, 9'h002, 9'h002}, 6'h01, 4'h1, 9'h000, 1'b1);
    cmd(CMD_ERASE, ACC_ALL, RES_OK);
    load({30'h0, 9'h005, 9'h005}, 6'h01, 4'h1, 9'h000, 1'b1);
    cmd(CMD_WRITE, ACC_CREATE, RES_OK);
    // key hashes one set above the filled one: a pointer left at 0 would hit
    load(48'h1, 6'h01, 4'h1, 9'h000, 1'b0);
    cmd(CMD_INIT, ACC_LOC, RES_OK);
    cmd(CMD_SEARCH, 4'hA, RES_NOT_FOUND);
    end_sim();
  end
endmodule
